// ---- logic/wdt_pkg.sv ----
// Constants used by the windowed watchdog, not by its tick synchroniser.
// Assumes a 40 MHz system clock and a slow tick pin of about 1 kHz.
package wdt_pkg;

	////////////////////////////////////////////////////////////////////////
	// Register map
	localparam logic [7:0] watchdog_control_offset = 8'h00;
	localparam logic [7:0] watchdog_status_offset  = 8'h01;

	////////////////////////////////////////////////////////////////////////
	// Field layout
	localparam int window_sel_msb  = 7;
	localparam int window_sel_lsb  = 4;
	localparam int timeout_sel_msb = 3;
	localparam int timeout_sel_lsb = 0;
	localparam int lock_bit        = 7;
	localparam int sync_bit        = 0;

	localparam logic [7:0] status_reset  = 8'h00;
	localparam logic [7:0] read_unmapped = 8'h00;

	////////////////////////////////////////////////////////////////////////
	// Timing
	localparam logic [3:0] sel_off      = 4'h0;
	localparam logic [3:0] sel_max      = 4'hb;
	localparam int         sel_shift    = 2;
	localparam int         count_width  = 14;
	localparam logic [1:0] cross_ticks  = 2'h2;

	typedef enum logic [2:0] {
		wd_idle,
		wd_normal,
		wd_open_first,
		wd_closed,
		wd_open
	} wd_state_t;

endpackage

// ---- logic/wdt_tick_sync.sv ----
// Brings the slow watchdog tick pin into the system clock domain.
// Assumes the tick pin is asynchronous to clock_i and much slower.
`timescale 1ns/100ps
module wdt_tick_sync
(
	input  wire logic clock_i,
	input  wire logic rstn_i,
	input  wire logic tick_pin_i,
	output logic      tick_en_o
);

	logic meta;
	logic stable;
	logic stable_d;

	always_ff @(posedge clock_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			meta     <= 1'b0;
			stable   <= 1'b0;
			stable_d <= 1'b0;
		end
		else
		begin
			meta     <= tick_pin_i;
			stable   <= meta;
			stable_d <= stable;
		end
	end

	// One enable pulse per rising edge of the tick
	always_ff @(posedge clock_i or negedge rstn_i)
	begin
		if (!rstn_i)
			tick_en_o <= 1'b0;
		else
			tick_en_o <= stable & ~stable_d;
	end

endmodule

// ---- logic/windowed_watchdog_timer.sv ----
// Windowed watchdog: register port, protected control, tick domain timer.
// Assumes the tick pin runs near 1 kHz; the other inputs are on clock_i.
//
// Added by the designer: strobed register access.
`timescale 1ns/100ps
module windowed_watchdog_timer
(
	input  wire logic       clock_i,
	input  wire logic       rstn_i,
	input  wire logic [7:0] addr_i,
	input  wire logic [7:0] wdata_i,
	input  wire logic       write_i,
	input  wire logic       read_i,
	output logic      [7:0] rdata_o,
	input  wire logic       change_protect_gate_i,
	input  wire logic [7:0] boot_config_fuse_i,
	input  wire logic       debug_halt_i,
	input  wire logic       restart_instruction_i,
	input  wire logic       watchdog_tick_clock_i,
	output logic            system_reset_o
);

	////////////////////////////////////////////////////////////////////////
	// Tick enable

	logic tick;

	wdt_tick_sync u_tick_sync
	(
		.clock_i    (clock_i),
		.rstn_i     (rstn_i),
		.tick_pin_i (watchdog_tick_clock_i),
		.tick_en_o  (tick)
	);

	////////////////////////////////////////////////////////////////////////
	// Register decode

	logic [7:0] primary_control;
	logic       lock;
	logic       fuse_loaded;
	logic       sync_pending_flag;
	logic [1:0] sync_ticks;
	logic [7:0] active_control;

	wire sel_control = (addr_i == wdt_pkg::watchdog_control_offset);
	wire sel_status  = (addr_i == wdt_pkg::watchdog_status_offset);

	wire ctrl_write_ok = write_i & sel_control & change_protect_gate_i & ~lock;
	wire lock_set      = write_i & sel_status & change_protect_gate_i
	                     & wdata_i[wdt_pkg::lock_bit];
	wire lock_clear    = write_i & sel_status & change_protect_gate_i & debug_halt_i
	                     & ~wdata_i[wdt_pkg::lock_bit];

	wire fuse_enabled  = boot_config_fuse_i[wdt_pkg::timeout_sel_msb:wdt_pkg::timeout_sel_lsb]
	                     != wdt_pkg::sel_off;

	wire [7:0] status_value = {lock, 6'h00, sync_pending_flag};

	wire [7:0] next_rdata = sel_control ? primary_control :
	                        sel_status  ? status_value : wdt_pkg::read_unmapped;

	always_ff @(posedge clock_i or negedge rstn_i)
	begin
		if (!rstn_i)
			rdata_o <= 8'h00;
		else if (read_i)
			rdata_o <= next_rdata;
		else
			rdata_o <= 8'h00;
	end

	////////////////////////////////////////////////////////////////////////
	// Control and lock

	// Fuse is sampled on the first edge after reset release, never by reset
	always_ff @(posedge clock_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			fuse_loaded     <= 1'b0;
			primary_control <= 8'h00;
			lock            <= wdt_pkg::status_reset[wdt_pkg::lock_bit];
		end
		else if (!fuse_loaded)
		begin
			fuse_loaded     <= 1'b1;
			primary_control <= boot_config_fuse_i;
			lock            <= fuse_enabled;
		end
		else
		begin
			if (ctrl_write_ok)
				primary_control <= wdata_i;
			if (lock_set)
				lock <= 1'b1;
			else if (lock_clear)
				lock <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Control transfer into the tick domain

	wire ctrl_start = ctrl_write_ok | ~fuse_loaded;
	wire ctrl_done  = sync_pending_flag & tick & (sync_ticks == wdt_pkg::cross_ticks - 2'h1);

	always_ff @(posedge clock_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			sync_pending_flag <= wdt_pkg::status_reset[wdt_pkg::sync_bit];
			sync_ticks        <= 2'h0;
		end
		else if (ctrl_start)
		begin
			sync_pending_flag <= 1'b1;
			sync_ticks        <= 2'h0;
		end
		else if (ctrl_done)
			sync_pending_flag <= 1'b0;
		else if (sync_pending_flag && tick)
			sync_ticks <= sync_ticks + 2'h1;
	end

	always_ff @(posedge clock_i or negedge rstn_i)
	begin
		if (!rstn_i)
			active_control <= 8'h00;
		else if (ctrl_done)
			active_control <= primary_control;
	end

	////////////////////////////////////////////////////////////////////////
	// Restart handshake

	// Request held until acknowledged on the second tick; extra pulses dropped
	logic       restart_req;
	logic [1:0] restart_ticks;

	wire restart_ack = restart_req & tick & (restart_ticks == wdt_pkg::cross_ticks - 2'h1);

	always_ff @(posedge clock_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			restart_req   <= 1'b0;
			restart_ticks <= 2'h0;
		end
		else if (!restart_req)
		begin
			restart_req   <= restart_instruction_i;
			restart_ticks <= 2'h0;
		end
		else if (restart_ack)
			restart_req <= 1'b0;
		else if (tick)
			restart_ticks <= restart_ticks + 2'h1;
	end

	////////////////////////////////////////////////////////////////////////
	// Period decode

	wire [3:0] win_code = active_control[wdt_pkg::window_sel_msb:wdt_pkg::window_sel_lsb];
	wire [3:0] per_code = active_control[wdt_pkg::timeout_sel_msb:wdt_pkg::timeout_sel_lsb];

	// Reserved codes behave as the longest period
	wire [3:0] win_clip = (win_code > wdt_pkg::sel_max) ? wdt_pkg::sel_max : win_code;
	wire [3:0] per_clip = (per_code > wdt_pkg::sel_max) ? wdt_pkg::sel_max : per_code;

	wire enabled     = (per_code != wdt_pkg::sel_off);
	wire window_mode = (win_code != wdt_pkg::sel_off);

	wire [wdt_pkg::count_width-1:0] closed_last =
		(wdt_pkg::count_width'(1) << (win_clip + 4'(wdt_pkg::sel_shift)))
		- wdt_pkg::count_width'(1);
	wire [wdt_pkg::count_width-1:0] open_last =
		(wdt_pkg::count_width'(1) << (per_clip + 4'(wdt_pkg::sel_shift)))
		- wdt_pkg::count_width'(1);

	////////////////////////////////////////////////////////////////////////
	// Timer state

	wdt_pkg::wd_state_t             state;
	wdt_pkg::wd_state_t             next_state;
	logic [wdt_pkg::count_width-1:0] count;
	logic [wdt_pkg::count_width-1:0] next_count;
	logic                            halted;
	logic                            next_fire;

	wire resume    = halted & ~debug_halt_i;
	wire at_open   = (count == open_last);
	wire at_closed = (count == closed_last);

	always_comb
	begin
		next_state = state;
		next_count = count;
		next_fire  = 1'b0;
		if (!enabled)
		begin
			next_state = wdt_pkg::wd_idle;
			next_count = '0;
		end
		else if (debug_halt_i)
			next_count = '0;
		else if (ctrl_done || resume || state == wdt_pkg::wd_idle)
		begin
			next_count = '0;
			next_state = window_mode ? wdt_pkg::wd_open_first : wdt_pkg::wd_normal;
		end
		else
		begin
			case (state)
				wdt_pkg::wd_normal:
				begin
					if (restart_ack)
						next_count = '0;
					else if (tick && at_open)
						next_fire = 1'b1;
					else if (tick)
						next_count = count + 1'b1;
				end
				wdt_pkg::wd_open_first, wdt_pkg::wd_open:
				begin
					if (restart_ack)
					begin
						next_count = '0;
						next_state = wdt_pkg::wd_closed;
					end
					else if (tick && at_open)
						next_fire = 1'b1;
					else if (tick)
						next_count = count + 1'b1;
				end
				wdt_pkg::wd_closed:
				begin
					if (restart_ack)
						next_fire = 1'b1;
					else if (tick && at_closed)
					begin
						next_count = '0;
						next_state = wdt_pkg::wd_open;
					end
					else if (tick)
						next_count = count + 1'b1;
				end
				default:
				begin
					next_count = '0;
					next_state = wdt_pkg::wd_idle;
				end
			endcase
		end
	end

	always_ff @(posedge clock_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			state  <= wdt_pkg::wd_idle;
			count  <= '0;
			halted <= 1'b0;
		end
		else
		begin
			state  <= next_state;
			count  <= next_count;
			halted <= debug_halt_i;
		end
	end

	// Held until the system reset comes back on rstn_i
	always_ff @(posedge clock_i or negedge rstn_i)
	begin
		if (!rstn_i)
			system_reset_o <= 1'b0;
		else if (next_fire)
			system_reset_o <= 1'b1;
	end

endmodule

// ---- dv/windowed_watchdog_timer_asserts.sv ----
// Port-level checks for the windowed watchdog.
// Assumes one clock domain; bound onto the design top below.
`timescale 1ns/100ps
module wdt_checker
(
	input  wire logic       clock_i,
	input  wire logic       rstn_i,
	input  wire logic [7:0] addr_i,
	input  wire logic       write_i,
	input  wire logic       read_i,
	input  wire logic [7:0] rdata_o,
	input  wire logic       debug_halt_i,
	input  wire logic       watchdog_tick_clock_i,
	input  wire logic       system_reset_o
);
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (!rstn_i);

	property p_rd_idle;
		!read_i |=> rdata_o == 8'h00;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
	property p_wr_quiet;
		write_i |=> rdata_o == 8'h00;
	endproperty
	a_wr_quiet: assert property (p_wr_quiet) else $error("write gave read data");
	property p_unmapped;
		read_i && addr_i > 8'h01 |=> rdata_o == 8'h00;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_pad;
		read_i && addr_i == 8'h01 |=> rdata_o[6:1] == 6'h00;
	endproperty
	a_pad: assert property (p_pad) else $error("status spare bits set");
	property p_sticky;
		system_reset_o |=> system_reset_o;
	endproperty
	a_sticky: assert property (p_sticky) else $error("system reset dropped");
	property p_dbg;
		debug_halt_i[*8] |=> !$rose(system_reset_o);
	endproperty
	a_dbg: assert property (p_dbg) else $error("reset while halted");
	property p_quiet;
		$rose(rstn_i) |-> (!system_reset_o)[*8];
	endproperty
	a_quiet: assert property (p_quiet) else $error("reset right after boot");
	// Timer only moves on a tick edge, a few clocks of sync later
	property p_tick;
		$stable(watchdog_tick_clock_i)[*8] |=> !$rose(system_reset_o);
	endproperty
	a_tick: assert property (p_tick) else $error("reset without tick");

	c_reset: cover property ($rose(system_reset_o));
	c_status: cover property (read_i && addr_i == 8'h01);
	c_debug: cover property (debug_halt_i[*8]);
endmodule

bind windowed_watchdog_timer wdt_checker chk (.clock_i(clock_i), .rstn_i(rstn_i), .addr_i(addr_i),
	.write_i(write_i), .read_i(read_i), .rdata_o(rdata_o), .debug_halt_i(debug_halt_i),
	.watchdog_tick_clock_i(watchdog_tick_clock_i), .system_reset_o(system_reset_o));

// ---- dv/wdt_core_model.sv ----
// Core-side model: restart pulses and the slow watchdog tick.
// Assumes the bench asks for restarts on clock_i edges.
`timescale 1ns/100ps
module wdt_core_model
#(
	parameter real tick_half_ns = 261.3
)
(
	input  wire logic clock_i,
	input  wire logic req_i,
	output logic      restart_instruction_o,
	output logic      watchdog_tick_clock_o
);
	// One clock pulse per requested cycle
	always @(posedge clock_i)
		restart_instruction_o <= req_i;
	// Tick far faster than real to keep runs short; odd period keeps phase unrelated
	initial
	begin
		watchdog_tick_clock_o = 1'b0;
		forever #(tick_half_ns) watchdog_tick_clock_o = ~watchdog_tick_clock_o;
	end
endmodule

// ---- dv/tb_windowed_watchdog_timer.sv ----
// Self-checking bench for the windowed watchdog.
// Assumes the core model makes the tick and the restart pulses.
`timescale 1ns/100ps
module tb_windowed_watchdog_timer;
	logic       clock_i, rstn_i, write_i, read_i, gate, debug, req, restart, tick, sys_rst;
	logic [7:0] addr, wdata, fuse, rdata, v;
	int         err_count, n_checks;
	typedef struct {logic wr; logic [7:0] a; logic [7:0] d; logic g; logic [7:0] e;} row_t;
	row_t       rows [5] = '{'{1'b1, 8'h00, 8'h13, 1'b0, 8'h00}, '{1'b1, 8'h00, 8'h02, 1'b1, 8'h02},
		'{1'b1, 8'h00, 8'h00, 1'b1, 8'h00}, '{1'b0, 8'h07, 8'h00, 1'b0, 8'h00},
		'{1'b0, 8'h01, 8'h00, 1'b0, 8'h00}};

	windowed_watchdog_timer dut (.clock_i(clock_i), .rstn_i(rstn_i), .addr_i(addr), .wdata_i(wdata),
		.write_i(write_i), .read_i(read_i), .rdata_o(rdata), .change_protect_gate_i(gate),
		.boot_config_fuse_i(fuse), .debug_halt_i(debug), .restart_instruction_i(restart),
		.watchdog_tick_clock_i(tick), .system_reset_o(sys_rst));
	wdt_core_model model (.clock_i(clock_i), .req_i(req), .restart_instruction_o(restart),
		.watchdog_tick_clock_o(tick));

	////////////////////////////////////////////////////////////////////////
	task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
		n_checks++;
		if (s !== e)
		begin
			err_count++;
			$display("[ERR] %s exp %h got %h", n, e, s);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clock_i);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic g);
		@(posedge clock_i);
		addr <= a;
		wdata <= d;
		gate <= g;
		write_i <= 1'b1;
		@(posedge clock_i);
		write_i <= 1'b0;
		gate <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clock_i);
		addr <= a;
		read_i <= 1'b1;
		@(posedge clock_i);
		read_i <= 1'b0;
		#1;
		v = rdata;
	endtask
	// Long settle so the control sync is done before the next access
	task automatic reset_dut(input logic [7:0] f);
		@(posedge clock_i);
		rstn_i <= 1'b0;
		fuse <= f;
		cyc(6);
		rstn_i <= 1'b1;
		cyc(80);
	endtask
	task automatic kick(input int n);
		@(posedge clock_i);
		req <= 1'b1;
		cyc(n);
		req <= 1'b0;
	endtask
	task automatic end_sim;
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		clock_i = 1'b0;
		forever #12.5 clock_i = ~clock_i;
	end
	initial
	begin
		#1000000;
		err_count++;
		end_sim;
	end
	initial
	begin
		{rstn_i, write_i, read_i, gate, debug, req} = '0;
		{addr, wdata, fuse} = '0;
		err_count = 0;
		n_checks = 0;
		reset_dut(8'h00);
		foreach (rows[i])
		begin
			if (rows[i].wr)
				wr(rows[i].a, rows[i].d, rows[i].g);
			cyc(80);
			rd(rows[i].a);
			chk("row", v, rows[i].e);
		end
		wr(8'h00, 8'h01, 1'b1);
		rd(8'h01);
		chk("sync_set", v, 8'h01);
		cyc(80);
		rd(8'h01);
		chk("sync_done", v, 8'h00);
		repeat (8)
		begin
			kick(1);
			cyc(90);
		end
		chk("kept_alive", sys_rst, 8'h00);
		cyc(250);
		chk("timed_out", sys_rst, 8'h01);
		reset_dut(8'h00);
		wr(8'h00, 8'h01, 1'b1);
		cyc(80);
		debug <= 1'b1;
		cyc(500);
		chk("debug_hold", sys_rst, 8'h00);
		debug <= 1'b0;
		cyc(400);
		chk("after_debug", sys_rst, 8'h01);
		reset_dut(8'h00);
		wr(8'h00, 8'h11, 1'b1);
		cyc(80);
		kick(2);
		cyc(120);
		chk("second_dropped", sys_rst, 8'h00);
		kick(1);
		cyc(100);
		chk("early_restart", sys_rst, 8'h01);
		reset_dut(8'h00);
		wr(8'h00, 8'h11, 1'b1);
		cyc(80);
		kick(1);
		cyc(300);
		chk("open_pending", sys_rst, 8'h00);
		cyc(200);
		chk("open_missed", sys_rst, 8'h01);
		reset_dut(8'h00);
		wr(8'h00, 8'h11, 1'b1);
		cyc(80);
		debug <= 1'b1;
		cyc(100);
		debug <= 1'b0;
		cyc(120);
		chk("resume_open", sys_rst, 8'h00);
		cyc(200);
		chk("resume_timeout", sys_rst, 8'h01);
		reset_dut(8'h01);
		rd(8'h01);
		chk("fuse_lock", v, 8'h80);
		rd(8'h00);
		chk("fuse_ctrl", v, 8'h01);
		wr(8'h00, 8'h00, 1'b1);
		wr(8'h01, 8'h00, 1'b1);
		rd(8'h00);
		chk("locked_ctrl", v, 8'h01);
		rd(8'h01);
		chk("lock_kept", v, 8'h80);
		@(posedge clock_i);
		debug <= 1'b1;
		wr(8'h01, 8'h00, 1'b1);
		rd(8'h01);
		chk("lock_cleared", v, 8'h00);
		end_sim;
	end
endmodule
